// File: dv/isa_host_model.sv
// host processor model issuing i/o cycles on the isa-style bus
`timescale 1ns/10ps
module isa_host_model (
  input  wire logic        clk,
  output logic      [15:0] addr,
  output logic             aen,
  output logic             iow_n,
  output logic             ior_n,
  output logic      [7:0]  din
);
  // ****************************************
  // idle bus
  // ****************************************
  initial begin
    addr  = 16'h0000;
    aen   = 1'b1;
    iow_n = 1'b1;
    ior_n = 1'b1;
    din   = 8'h00;
  end
  // ****************************************
  // i/o cycles
  // ****************************************
  // strobe low for three cycles, address and data held throughout
  task automatic start(input logic [15:0] a, input logic e, input logic wr, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    aen  <= e;
    din  <= d;
    if (wr) begin
      iow_n <= 1'b0;
    end else begin
      ior_n <= 1'b0;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask
  // released lines inverted, aen high: a stale address must not decode
  task automatic stop();
    @(posedge clk);
    iow_n <= 1'b1;
    ior_n <= 1'b1;
    aen   <= 1'b1;
    addr  <= ~addr;
    din   <= ~din;
  endtask
  task automatic write(input logic [15:0] a, input logic [7:0] d);
    start(a, 1'b0, 1'b1, d);
    stop();
  endtask
endmodule

// File: dv/port_address_irq_decoder_bench.sv
// self-checking bench for the port address and interrupt decoder
`timescale 1ns/10ps
module port_address_irq_decoder_bench;
  // ****************************************
  // signals
  // ****************************************
  localparam int EE_CYC = 20;
  localparam int LIMIT  = 20000;
  typedef struct {logic [15:0] a; logic e; logic [7:0] s; logic o; logic [2:0] r;} row_t;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata, r;
  logic        hreadyout, hresp, irq, oe, aen, iow_n, ior_n;
  logic        pdis    = 1'b0;
  logic [15:0] io_addr;
  logic [7:0]  din, dout, ch_sel;
  logic [7:0]  ch_irq  = 8'h00;
  logic [5:0]  jfit    = 6'h1f;
  logic [5:0]  host_irq;
  logic [2:0]  ch_reg;
  int          mismatches = 0;
  int          checks     = 0;
  int          cycles     = 0;
  // bases chosen clear of other functions: control 200h, channels 100h..13fh
  row_t rows [17] = '{
    '{16'h0100, 0, 8'h01, 0, 3'h0}, '{16'h0107, 0, 8'h01, 0, 3'h7},
    '{16'h013f, 0, 8'h80, 0, 3'h7}, '{16'h0138, 1, 8'h00, 0, 3'h0},
    '{16'h0140, 0, 8'h00, 0, 3'h0}, '{16'h00f8, 0, 8'h00, 0, 3'h0},
    '{16'h8100, 0, 8'h00, 0, 3'h0}, '{16'h0500, 0, 8'h00, 1, 3'h0},
    '{16'h0508, 0, 8'h00, 0, 3'h0}, '{16'h0500, 1, 8'h00, 0, 3'h0},
    '{16'h03f8, 0, 8'h01, 0, 3'h0}, '{16'h03ff, 0, 8'h01, 0, 3'h7},
    '{16'h07f8, 0, 8'h00, 1, 3'h0}, '{16'h0500, 0, 8'h00, 0, 3'h0},
    '{16'h0100, 0, 8'h00, 0, 3'h0}, '{16'h03f8, 0, 8'h00, 0, 3'h0},
    '{16'h07f8, 0, 8'h00, 0, 3'h0}};
  logic [3:0]  lv [7] = '{4'h2, 4'h3, 4'h5, 4'h7, 4'ha, 4'hb, 4'h4};
  // ****************************************
  // design and host
  // ****************************************
  always #12.5 clk_sys = ~clk_sys;
  port_address_irq_decoder #(.NCH(8), .EE_WRITE_CYC(EE_CYC)) dut (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .IRQ(irq),
    .HOST_ADDR(io_addr), .HOST_AEN(aen), .HOST_IOW_N(iow_n), .HOST_IOR_N(ior_n),
    .HOST_DIN(din), .HOST_DOUT(dout), .HOST_DOUT_OE(oe), .ADDR_JUMPER_FIT(jfit),
    .PORT_DISABLE_JUMPER(pdis), .CH_IRQ(ch_irq), .CH_SEL(ch_sel), .CH_REG(ch_reg),
    .HOST_IRQ(host_irq));
  isa_host_model host (.clk(clk_sys), .addr(io_addr), .aen(aen), .iow_n(iow_n),
    .ior_n(ior_n), .din(din));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rows_check(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      host.start(rows[i].a, rows[i].e, 1'b0, 8'h00);
      chk(ch_sel, rows[i].s);
      chk(oe, rows[i].o);
      chk(ch_reg, rows[i].r);
      if (rows[i].o) begin
        chk(dout, ch_irq);
      end
      host.stop();
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      results();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    chk({ch_sel, irq, host_irq}, 32'h0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    // load takes nch+1 cycles, no host access needed
    repeat (12) @(posedge clk_sys);
    chk(irq, 1'b0);
    ahb(1'b0, decode_pkg::OFS_MASK, 32'h0, r);
    chk(r, {28'h0, decode_pkg::MASK_RST});
    chk(hresp, 1'b0);
    ahb(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'h0);
    ch_irq <= 8'h5a;
    rows_check(0, 9);
    host.write(16'h0200, 8'h00);
    ch_irq <= 8'h10;
    for (int k = 0; k < 7; k++) begin
      host.write(16'h0201, 8'h09);
      host.write(16'h0202, {4'h0, lv[k]});
      repeat (EE_CYC + 4) @(posedge clk_sys);
      host.write(16'h0203, 8'h00);
      repeat (12) @(posedge clk_sys);
      #1;
      chk(host_irq, (k < 6) ? (6'h01 << k) : 6'h00);
    end
    ahb(1'b0, decode_pkg::OFS_STATUS, 32'h0, r);
    chk(r[2], 1'b1);
    ahb(1'b1, decode_pkg::OFS_STATUS, 32'hf, r);
    // control write while memory is busy must be flagged, not taken
    host.write(16'h0201, 8'h01);
    host.write(16'h0202, 8'h7f);
    host.write(16'h0200, 8'h00);
    ahb(1'b0, decode_pkg::OFS_INFO, 32'h0, r);
    chk(r[13], 1'b1);
    repeat (EE_CYC + 4) @(posedge clk_sys);
    ahb(1'b0, decode_pkg::OFS_STATUS, 32'h0, r);
    chk(r[3:1], 3'b101);
    host.write(16'h0203, 8'h00);
    repeat (12) @(posedge clk_sys);
    ahb(1'b0, decode_pkg::OFS_INFO, 32'h0, r);
    chk(r[6:0], 7'h7f);
    chk(r[14:8], 7'h44);
    rows_check(10, 14);
    pdis <= 1'b1;
    rows_check(15, 16);
    ahb(1'b1, decode_pkg::OFS_STATUS, 32'hf, r);
    host.write(16'h0203, 8'h00);
    repeat (12) @(posedge clk_sys);
    ahb(1'b0, decode_pkg::OFS_STATUS, 32'h0, r);
    chk(r[0], 1'b1);
    ahb(1'b1, decode_pkg::OFS_MASK, 32'h1, r);
    @(posedge clk_sys);
    #1;
    chk(irq, 1'b1);
    ahb(1'b1, decode_pkg::OFS_STATUS, 32'h1, r);
    @(posedge clk_sys);
    #1;
    chk(irq, 1'b0);
    // load started from the register bus instead of the host
    ahb(1'b1, decode_pkg::OFS_CTRL, 32'h1, r);
    repeat (12) @(posedge clk_sys);
    ahb(1'b0, decode_pkg::OFS_STATUS, 32'h0, r);
    chk(r[0], 1'b1);
    results();
  end
endmodule

// File: pkg/decode_pkg.sv
// constants for the port address and interrupt decoder
package decode_pkg;
  // ****************************************
  // ahb register map
  // ****************************************
  localparam logic [7:0]  OFS_STATUS = 8'h00;
  localparam logic [7:0]  OFS_MASK   = 8'h04;
  localparam logic [7:0]  OFS_INFO   = 8'h08;
  localparam logic [7:0]  OFS_CTRL   = 8'h0c;
  localparam int          EV_LOAD    = 0;
  localparam int          EV_EEWR    = 1;
  localparam int          EV_BADIRQ  = 2;
  localparam int          EV_BUSYACC = 3;
  localparam int          NEV        = 4;
  localparam logic [3:0]  MASK_RST   = 4'h0;
  // ****************************************
  // host i/o decode
  // ****************************************
  localparam logic [6:0]  CH_MIN     = 7'h20;
  localparam logic [5:0]  CTRL_MIN   = 6'h10;
  localparam logic [5:0]  HI_NONE    = 6'h00;
  localparam logic [5:0]  HI_SHARE   = 6'h01;
  localparam logic [3:0]  CO_IRQEN   = 4'h0;
  localparam logic [3:0]  CO_EEADDR  = 4'h1;
  localparam logic [3:0]  CO_EEDATA  = 4'h2;
  localparam logic [3:0]  CO_LOAD    = 4'h3;
  // ****************************************
  // config memory and irq levels
  // ****************************************
  localparam int          EE_DEPTH   = 16;
  localparam logic [3:0]  EE_CH_FIRST = 4'h1;
  localparam logic [3:0]  EE_IRQ     = 4'h9;
  localparam logic [7:0]  EE_CH_RST  = 8'h20;
  localparam logic [7:0]  EE_IRQ_RST = 8'h05;
  localparam int          NLEVEL     = 6;
  localparam logic [3:0]  IRQ_LEVEL [NLEVEL] = '{4'h2, 4'h3, 4'h5, 4'h7, 4'ha, 4'hb};
  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          EE_WRITE_NS   = 2000000;
  localparam int          EE_WRITE_CYC  = (EE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_LOAD = 1'b1} load_st_t;
endpackage

// File: rtl/port_address_irq_decoder.sv
// port address decode, shared interrupt routing and config load
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
// What this block does
// - shared interrupt goes only to level 2, 3, 5, 7, 10 or 11.
// - all channels share one host line, chosen by the stored irq entry.
// - control block and each channel decode own base within 100h to 3f8h.
// - control block base comes only from the six address jumpers.
// - channel bases and irq number come from registers loaded from memory.
// - sharing status address follows channel a base and moves with it.
// - channel byte matches a9..a3, eight addresses from byte times eight.
// - jumper missing means line must be 1, fitted means 0, a9..a4.
// - a3..a0 pick registers inside the block, not the block itself.
// - sharing status register sits at channel a base plus 400h.
// - control offsets 0..3: irq enable, mem address, mem data, load.
// - after reset the stored config is copied without host action.
// - port disable jumper blocks channel decode, control block still answers.
module port_address_irq_decoder #(
  parameter int NCH          = 8,
  parameter int EE_WRITE_CYC = decode_pkg::EE_WRITE_CYC
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RST_N,
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  output logic                   IRQ,
  input  wire logic [15:0]       HOST_ADDR,
  input  wire logic              HOST_AEN,
  input  wire logic              HOST_IOW_N,
  input  wire logic              HOST_IOR_N,
  input  wire logic [7:0]        HOST_DIN,
  output logic      [7:0]        HOST_DOUT,
  output logic                   HOST_DOUT_OE,
  input  wire logic [5:0]        ADDR_JUMPER_FIT,
  input  wire logic              PORT_DISABLE_JUMPER,
  input  wire logic [NCH-1:0]    CH_IRQ,
  output logic      [NCH-1:0]    CH_SEL,
  output logic      [2:0]        CH_REG,
  output logic      [5:0]        HOST_IRQ
);
  localparam int CW = $clog2(EE_WRITE_CYC + 1);
  localparam logic [CW-1:0] EE_LAST = CW'(EE_WRITE_CYC - 1);
  localparam logic [3:0] LD_LAST = 4'(NCH);
  localparam int LOAD_MAX = NCH + 2;

  decode_pkg::load_st_t  st_q;
  logic [3:0]            ld_idx_q;
  logic [7:0]            ee_mem [decode_pkg::EE_DEPTH];
  logic [3:0]            ee_addr_q;
  logic [CW-1:0]         ee_cnt_q;
  logic                  ee_busy;
  logic [6:0]            ch_base_q [NCH];
  logic [3:0]            irq_num_q;
  logic                  irq_en_q;
  logic                  iow_prev_q;
  logic                  iow_fall;
  logic                  ctrl_hit;
  logic                  isr_hit;
  logic                  ctrl_wr;
  logic [3:0]            ctrl_ofs;
  logic                  load_req;
  logic                  irq_ok;
  logic                  ch_irq_any;
  localparam int NEV_W = decode_pkg::NEV;
  logic [NEV_W-1:0]      ev;
  logic [NEV_W-1:0]      stat_q;
  logic [NEV_W-1:0]      mask_q;
  logic                  ph_q;
  logic                  ph_wr_q;
  logic [7:0]            ph_ofs_q;
  logic                  ctrl_load;

  // ****************************************
  // host i/o decode
  // ****************************************
  assign iow_fall = !HOST_IOW_N && iow_prev_q;
  assign ctrl_hit = !HOST_AEN && HOST_ADDR[15:10] == decode_pkg::HI_NONE
                    && HOST_ADDR[9:4] == ~ADDR_JUMPER_FIT
                    && ~ADDR_JUMPER_FIT >= decode_pkg::CTRL_MIN;
  assign isr_hit = !HOST_AEN && !PORT_DISABLE_JUMPER
                   && HOST_ADDR[15:10] == decode_pkg::HI_SHARE
                   && HOST_ADDR[9:3] == ch_base_q[0]
                   && ch_base_q[0] >= decode_pkg::CH_MIN;
  assign ctrl_ofs = HOST_ADDR[3:0];
  assign ctrl_wr  = ctrl_hit && iow_fall;
  assign CH_REG   = HOST_ADDR[2:0];

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      assign CH_SEL[c] = !HOST_AEN && !PORT_DISABLE_JUMPER
                         && HOST_ADDR[15:10] == decode_pkg::HI_NONE
                         && HOST_ADDR[9:3] == ch_base_q[c]
                         && ch_base_q[c] >= decode_pkg::CH_MIN;
    end
  endgenerate

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      iow_prev_q <= 1'b1;
    end else begin
      iow_prev_q <= HOST_IOW_N;
    end
  end

  // sharing status: one bit per channel interrupt
  assign HOST_DOUT_OE = isr_hit && !HOST_IOR_N;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      HOST_DOUT <= 8'h00;
    end else begin
      HOST_DOUT <= 8'(CH_IRQ);
    end
  end

  // ****************************************
  // control block and config memory
  // ****************************************
  assign ee_busy = ee_cnt_q != '0;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ee_addr_q <= 4'h0;
      ee_cnt_q  <= '0;
      for (int i = 0; i < decode_pkg::EE_DEPTH; i++) begin
        ee_mem[i] <= 8'h00;
      end
      for (int i = 0; i < NCH; i++) begin
        ee_mem[decode_pkg::EE_CH_FIRST + 4'(i)] <= decode_pkg::EE_CH_RST + 8'(i);
      end
      ee_mem[decode_pkg::EE_IRQ] <= decode_pkg::EE_IRQ_RST;
    end else begin
      if (ee_busy) begin
        ee_cnt_q <= ee_cnt_q - 1'b1;
      end
      // writes during the memory's busy time are dropped, not queued
      if (ctrl_wr && !ee_busy && ctrl_ofs == decode_pkg::CO_EEADDR) begin
        ee_addr_q <= HOST_DIN[3:0];
      end
      if (ctrl_wr && !ee_busy && ctrl_ofs == decode_pkg::CO_EEDATA) begin
        ee_mem[ee_addr_q] <= HOST_DIN;
        ee_cnt_q          <= EE_LAST;
      end
    end
  end

  // irq enable: explicit command, or first write into any channel
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_en_q <= 1'b0;
    end else if (iow_fall && ((ctrl_hit && !ee_busy && ctrl_ofs == decode_pkg::CO_IRQEN)
                 || |CH_SEL)) begin
      irq_en_q <= 1'b1;
    end
  end

  // ****************************************
  // load of decode registers
  // ****************************************
  assign load_req = (ctrl_wr && ctrl_ofs == decode_pkg::CO_LOAD || ctrl_load) && !ee_busy;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_q     <= decode_pkg::ST_LOAD;
      ld_idx_q <= 4'h0;
    end else begin
      case (st_q)
        decode_pkg::ST_IDLE: begin
          if (load_req) begin
            st_q     <= decode_pkg::ST_LOAD;
            ld_idx_q <= 4'h0;
          end
        end
        decode_pkg::ST_LOAD: begin
          if (ld_idx_q == LD_LAST) begin
            st_q <= decode_pkg::ST_IDLE;
          end
          ld_idx_q <= ld_idx_q + 4'h1;
        end
        default: begin
          st_q <= decode_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_num_q <= 4'h0;
      for (int i = 0; i < NCH; i++) begin
        ch_base_q[i] <= 7'h00;
      end
    end else if (st_q == decode_pkg::ST_LOAD) begin
      if (ld_idx_q == LD_LAST) begin
        irq_num_q <= ee_mem[decode_pkg::EE_IRQ][3:0];
      end else begin
        ch_base_q[ld_idx_q[2:0]] <= ee_mem[decode_pkg::EE_CH_FIRST + ld_idx_q][6:0];
      end
    end
  end

  // ****************************************
  // interrupt routing
  // ****************************************
  assign ch_irq_any = |CH_IRQ;
  generate
    for (genvar l = 0; l < decode_pkg::NLEVEL; l++) begin : g_lvl
      // unsupported numbers match no level and leave every line quiet
      assign HOST_IRQ[l] = irq_en_q && ch_irq_any
                           && irq_num_q == decode_pkg::IRQ_LEVEL[l];
    end
  endgenerate
  // judged on the number alone, so a line driven for a bad number is caught
  assign irq_ok = irq_num_q inside
                  {decode_pkg::IRQ_LEVEL[0], decode_pkg::IRQ_LEVEL[1],
                   decode_pkg::IRQ_LEVEL[2], decode_pkg::IRQ_LEVEL[3],
                   decode_pkg::IRQ_LEVEL[4], decode_pkg::IRQ_LEVEL[5]};

  // ****************************************
  // ahb-lite registers and events
  // ****************************************
  always_comb begin
    ev                        = '0;
    ev[decode_pkg::EV_LOAD]   = st_q == decode_pkg::ST_LOAD && ld_idx_q == LD_LAST;
    ev[decode_pkg::EV_EEWR]   = ee_cnt_q == CW'(1);
    ev[decode_pkg::EV_BADIRQ] = ev[decode_pkg::EV_LOAD] && !(ee_mem[decode_pkg::EE_IRQ][3:0]
                                inside {decode_pkg::IRQ_LEVEL[0], decode_pkg::IRQ_LEVEL[1],
                                decode_pkg::IRQ_LEVEL[2], decode_pkg::IRQ_LEVEL[3],
                                decode_pkg::IRQ_LEVEL[4], decode_pkg::IRQ_LEVEL[5]});
    ev[decode_pkg::EV_BUSYACC] = ctrl_wr && ee_busy;
  end

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign IRQ       = |(stat_q & mask_q);
  assign ctrl_load = ph_q && ph_wr_q && ph_ofs_q == decode_pkg::OFS_CTRL && HWDATA[0];

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ph_q     <= 1'b0;
      ph_wr_q  <= 1'b0;
      ph_ofs_q <= 8'h00;
      HRDATA   <= 32'h0000_0000;
    end else begin
      ph_q <= HSEL && HREADY && HTRANS[1];
      if (HSEL && HREADY && HTRANS[1]) begin
        ph_wr_q  <= HWRITE;
        ph_ofs_q <= HADDR[7:0];
        case (HADDR[7:0])
          decode_pkg::OFS_STATUS: HRDATA <= 32'(stat_q);
          decode_pkg::OFS_MASK:   HRDATA <= 32'(mask_q);
          decode_pkg::OFS_INFO:   HRDATA <= {16'h0000, 1'b0, irq_en_q, ee_busy,
                                             st_q == decode_pkg::ST_LOAD, irq_num_q,
                                             1'b0, ch_base_q[0]};
          default:                HRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      stat_q <= '0;
      mask_q <= decode_pkg::MASK_RST;
    end else begin
      // a new event in the clearing cycle stays set
      if (ph_q && ph_wr_q && ph_ofs_q == decode_pkg::OFS_STATUS) begin
        stat_q <= (stat_q & ~HWDATA[NEV_W-1:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
      if (ph_q && ph_wr_q && ph_ofs_q == decode_pkg::OFS_MASK) begin
        mask_q <= HWDATA[NEV_W-1:0];
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence load_last_s;
    st_q == decode_pkg::ST_LOAD && ld_idx_q == LD_LAST;
  endsequence
  sequence back_idle_s;
    st_q == decode_pkg::ST_IDLE;
  endsequence

  irq_onehot_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $onehot0(HOST_IRQ) && (HOST_IRQ == '0 || irq_ok))
    else $error("irq routed to an unsupported level");
  irq_share_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (HOST_IRQ != '0) |-> (irq_en_q && |CH_IRQ))
    else $error("host irq without channel request");
  ctrl_jumper_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ctrl_hit |-> HOST_ADDR[9:4] == ~ADDR_JUMPER_FIT && HOST_ADDR[9:4] >= 6'h10)
    else $error("control block hit away from jumper base");
  ch_range_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CH_SEL != '0) |-> HOST_ADDR[9:3] >= 7'h20 && HOST_ADDR[15:10] == 6'h00)
    else $error("channel decoded outside 100h to 3f8h");
  ch_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    CH_SEL[0] |-> HOST_ADDR[9:3] == ch_base_q[0] && CH_REG == HOST_ADDR[2:0])
    else $error("channel a select does not match its byte");
  isr_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    isr_hit |-> HOST_ADDR[15:3] == {6'h01, ch_base_q[0]})
    else $error("status register not at channel a plus 400h");
  port_off_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (PORT_DISABLE_JUMPER || HOST_AEN) |-> CH_SEL == '0 && !isr_hit)
    else $error("channel decoded while disabled or during dma");
  aen_ctrl_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    HOST_AEN |-> !ctrl_hit)
    else $error("control block decoded during dma");
  load_done_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(st_q == decode_pkg::ST_LOAD) |-> ##[1:LOAD_MAX] back_idle_s)
    else $error("config load did not finish");
  load_irq_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    load_last_s |=> back_idle_s and (irq_num_q == $past(ee_mem[decode_pkg::EE_IRQ][3:0])))
    else $error("irq number not taken from memory");
  ee_busy_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (ctrl_wr && !ee_busy && ctrl_ofs == 4'h2) |=> ee_busy && ee_cnt_q == EE_LAST)
    else $error("memory write did not start busy time");
endmodule
